// ### logic/sdoc_top.v
// Contract
// - cubic sinc then moving average per channel
// - normalise to unity low-frequency gain
// - settling is (3 + avg - 1) times cubic ratio
// - averaging only above total ratio 512
// - ratio field maps to cubic and average ratios
// - resolution 17/20/23/24 bits from ratio
// - one resolution for all channels
// - discard unsettled results, ready only when settled
// - first after settling, then one output period
// - latency equals settling time
// - 24-bit two's complement, msb first
// - left-justify, zero fill low bits; the 7fffff clamp comes after the fill and leaves them set
// - clamp to 7fffff and 800000
// - width field gives 16/24/32-bit words
// - sample strobe paces input, output rate delivery
`include "sdoc_defines.vh"

module sdoc_top (
  // clock and reset
  input wire CLK,
  input wire RST_B,
  // modulator side
  input wire MOD_SAMPLE_STB,
  input wire [`SDOC_NCH-1:0] MOD_BITS,
  // configuration
  input wire [2:0] RATIO_SEL,
  input wire [1:0] WIDTH_SEL,
  // result side
  output reg DATA_READY,
  output reg SETTLED,
  output reg [`SDOC_NCH*`SDOC_OUT_W-1:0] CH_DATA
);

  // ==================================================
  // ratio decode
  function [3:0] cube_shift;
    input [2:0] sel;
    begin
      if (sel >= `SDOC_RATIO_512) begin
        cube_shift = `SDOC_CUBE_SHIFT_MAX;
      end else begin
        cube_shift = `SDOC_CUBE_SHIFT_MIN + {1'b0, sel};
      end
    end
  endfunction

  function [1:0] avg_shift;
    input [2:0] sel;
    begin
      if (sel > `SDOC_RATIO_512) begin
        avg_shift = sel[1:0] - 2'h0;
      end else begin
        avg_shift = 2'h0;
      end
    end
  endfunction

  function [4:0] res_bits;
    input [2:0] sel;
    begin
      case (sel)
        `SDOC_RATIO_32: res_bits = `SDOC_RES_32;
        `SDOC_RATIO_64: res_bits = `SDOC_RES_64;
        `SDOC_RATIO_128: res_bits = `SDOC_RES_128;
        default: res_bits = `SDOC_RES_MAX;
      endcase
    end
  endfunction

  // ==================================================
  // shared pacing, one set for all channels
  localparam ST_SETTLE = 2'b01;
  localparam ST_RUN = 2'b10;

  reg [1:0] state_q, state_d;
  reg [2:0] ratio_q;
  reg [8:0] cube_cnt_q;
  reg [1:0] ncube_q;
  reg [2:0] avg_cnt_q;
  reg emit_q;

  wire [3:0] k3 = cube_shift(ratio_q);
  wire [1:0] k1 = avg_shift(ratio_q);
  wire [8:0] cube_last = 9'h1ff >> (4'h9 - k3);
  wire [2:0] avg_last = 3'h7 >> (2'h3 - k1);
  // a ratio change is seen one cycle before the counters switch over
  wire restart = (RATIO_SEL != ratio_q);
  wire dec = MOD_SAMPLE_STB && (cube_cnt_q == cube_last);
  // the first two cubic outputs still hold reset history
  wire acc_en = dec && ncube_q[1];
  wire acc_first = (avg_cnt_q == 3'h0);
  wire acc_last = (avg_cnt_q == avg_last);
  wire emit = acc_en && acc_last;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_SETTLE: begin
        if (emit) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_SETTLE;
      end
    endcase
    if (restart) begin
      state_d = ST_SETTLE;
    end
  end

  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_q <= ST_SETTLE;
      ratio_q <= `SDOC_RATIO_RST;
      cube_cnt_q <= 9'h0;
      ncube_q <= 2'h0;
      avg_cnt_q <= 3'h0;
      emit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ratio_q <= RATIO_SEL;
      if (restart) begin
        cube_cnt_q <= 9'h0;
        ncube_q <= 2'h0;
        avg_cnt_q <= 3'h0;
        emit_q <= 1'b0;
      end else begin
        emit_q <= emit;
        if (MOD_SAMPLE_STB) begin
          cube_cnt_q <= dec ? 9'h0 : cube_cnt_q + 9'h1;
        end
        if (dec && !ncube_q[1]) begin
          ncube_q <= ncube_q + 2'h1;
        end
        if (acc_en) begin
          avg_cnt_q <= acc_last ? 3'h0 : avg_cnt_q + 3'h1;
        end
      end
    end
  end

  // ==================================================
  // per-channel filters
  wire [`SDOC_NCH*`SDOC_ACC_W-1:0] raw_all;

  genvar gi;
  generate
    for (gi = 0; gi < `SDOC_NCH; gi = gi + 1) begin : g_ch
      wire signed [`SDOC_ACC_W-1:0] raw;
      sdoc_chan u_chan (
        .clk(CLK),
        .rst_b(RST_B),
        .restart(restart),
        .smp(MOD_SAMPLE_STB),
        .dec(dec),
        .acc_en(acc_en),
        .acc_first(acc_first),
        .acc_last(acc_last),
        .mod_bit(MOD_BITS[gi]),
        .raw_q(raw)
      );
      assign raw_all[gi*`SDOC_ACC_W +: `SDOC_ACC_W] = raw;
    end
  endgenerate

  // ==================================================
  // output coding
  // gain of the chain is 2^(3*k3 + k1); full scale maps to 2^23
  function [23:0] code24;
    input [`SDOC_ACC_W-1:0] raw;
    input [3:0] c3;
    input [1:0] c1;
    input [4:0] res;
    reg signed [`SDOC_WIDE_W-1:0] wide;
    reg signed [`SDOC_WIDE_W-1:0] norm;
    reg [4:0] rshift;
    reg [23:0] keep;
    begin
      wide = {{8{raw[`SDOC_ACC_W-1]}}, raw};
      wide = wide <<< `SDOC_PRE_SHIFT;
      rshift = {1'b0, c3} * 5'h3 + {3'b0, c1} + {1'b0, `SDOC_PRE_SHIFT} - `SDOC_FS_BIT;
      norm = wide >>> rshift;
      keep = 24'hffffff << (`SDOC_RES_MAX - res);
      // truncation first, so a clamped word may differ from the resolution grid
      norm = norm & {{16{1'b1}}, keep};
      if (norm > $signed({16'h0, `SDOC_SAT_POS})) begin
        code24 = `SDOC_SAT_POS;
      end else if (norm < $signed({16'hffff, `SDOC_SAT_NEG})) begin
        code24 = `SDOC_SAT_NEG;
      end else begin
        code24 = norm[23:0];
      end
    end
  endfunction

  function [`SDOC_OUT_W-1:0] fmt;
    input [23:0] w;
    input [1:0] sel;
    begin
      case (sel)
        `SDOC_WIDTH_16: fmt = {16'h0, w[23:8]};
        `SDOC_WIDTH_24: fmt = {8'h0, w};
        `SDOC_WIDTH_32Z: fmt = {w, 8'h0};
        `SDOC_WIDTH_32S: fmt = {{8{w[23]}}, w};
        default: fmt = {8'h0, w};
      endcase
    end
  endfunction

  // one resolution from the shared ratio register for every lane
  wire [4:0] res_now = res_bits(ratio_q);

  integer ci;
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      DATA_READY <= 1'b0;
      SETTLED <= 1'b0;
      CH_DATA <= {(`SDOC_NCH*`SDOC_OUT_W){1'b0}};
    end else begin
      DATA_READY <= emit_q && !restart;
      // drop at once on a ratio change, state_q still shows the old run here
      SETTLED <= (state_q == ST_RUN) && !restart;
      if (emit_q && !restart) begin
        for (ci = 0; ci < `SDOC_NCH; ci = ci + 1) begin
          CH_DATA[ci*`SDOC_OUT_W +: `SDOC_OUT_W] <= fmt(code24(
            raw_all[ci*`SDOC_ACC_W +: `SDOC_ACC_W], k3, k1, res_now), WIDTH_SEL);
        end
      end
    end
  end

endmodule // sdoc_top

// ### logic/sdoc_defines.vh
`ifndef SDOC_DEFINES_VH
`define SDOC_DEFINES_VH

// ==================================================
// channel count and datapath widths
`define SDOC_NCH 6
`define SDOC_ACC_W 32
`define SDOC_WIDE_W 40
`define SDOC_OUT_W 32

// ==================================================
// ratio_select_field codes
`define SDOC_RATIO_32 3'h0
`define SDOC_RATIO_64 3'h1
`define SDOC_RATIO_128 3'h2
`define SDOC_RATIO_256 3'h3
`define SDOC_RATIO_512 3'h4
`define SDOC_RATIO_1024 3'h5
`define SDOC_RATIO_2048 3'h6
`define SDOC_RATIO_4096 3'h7
`define SDOC_RATIO_RST 3'h0

// ==================================================
// cubic stage: ratio is 1 << shift
`define SDOC_CUBE_SHIFT_MIN 4'h5
`define SDOC_CUBE_SHIFT_MAX 4'h9
`define SDOC_CUBE_ORDER 4'h3

// ==================================================
// normalisation: raw value scaled to full scale 1 << FS_BIT
`define SDOC_FS_BIT 5'h17
`define SDOC_PRE_SHIFT 4'h8

// ==================================================
// resolutions in bits
`define SDOC_RES_32 5'h11
`define SDOC_RES_64 5'h14
`define SDOC_RES_128 5'h17
`define SDOC_RES_MAX 5'h18

// ==================================================
// saturation codes
`define SDOC_SAT_POS 24'h7fffff
`define SDOC_SAT_NEG 24'h800000

// ==================================================
// output width field codes
`define SDOC_WIDTH_16 2'h0
`define SDOC_WIDTH_24 2'h1
`define SDOC_WIDTH_32Z 2'h2
`define SDOC_WIDTH_32S 2'h3

`endif

// ### logic/sdoc_chan.v
`include "sdoc_defines.vh"

module sdoc_chan (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // control shared by all channels
  input wire restart,
  input wire smp,
  input wire dec,
  input wire acc_en,
  input wire acc_first,
  input wire acc_last,
  // modulator bit: 1 is +1, 0 is -1
  input wire mod_bit,
  // raw block sum, unnormalised
  output reg signed [`SDOC_ACC_W-1:0] raw_q
);

  // ==================================================
  // integrators at the sample rate
  // wraparound is harmless: combs undo it while width exceeds log2 of the gain
  reg signed [`SDOC_ACC_W-1:0] int1_q, int2_q, int3_q;
  reg signed [`SDOC_ACC_W-1:0] dly1_q, dly2_q, dly3_q;
  reg signed [`SDOC_ACC_W-1:0] avg_q;
  wire signed [`SDOC_ACC_W-1:0] x = mod_bit ? 32'sh00000001 : 32'shffffffff;
  wire signed [`SDOC_ACC_W-1:0] int1_d = int1_q + x;
  wire signed [`SDOC_ACC_W-1:0] int2_d = int2_q + int1_d;
  wire signed [`SDOC_ACC_W-1:0] int3_d = int3_q + int2_d;
  // ==================================================
  // combs at the cubic-stage rate
  wire signed [`SDOC_ACC_W-1:0] comb1 = int3_d - dly1_q;
  wire signed [`SDOC_ACC_W-1:0] comb2 = comb1 - dly2_q;
  wire signed [`SDOC_ACC_W-1:0] cube = comb2 - dly3_q;
  wire signed [`SDOC_ACC_W-1:0] avg_d = acc_first ? cube : avg_q + cube;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      int1_q <= 32'sh0;
      int2_q <= 32'sh0;
      int3_q <= 32'sh0;
      dly1_q <= 32'sh0;
      dly2_q <= 32'sh0;
      dly3_q <= 32'sh0;
      avg_q <= 32'sh0;
      raw_q <= 32'sh0;
    end else if (restart) begin
      int1_q <= 32'sh0;
      int2_q <= 32'sh0;
      int3_q <= 32'sh0;
      dly1_q <= 32'sh0;
      dly2_q <= 32'sh0;
      dly3_q <= 32'sh0;
      avg_q <= 32'sh0;
    end else begin
      if (smp) begin
        int1_q <= int1_d;
        int2_q <= int2_d;
        int3_q <= int3_d;
      end
      if (dec) begin
        dly1_q <= int3_d;
        dly2_q <= comb1;
        dly3_q <= comb2;
      end
      if (acc_en) begin
        avg_q <= avg_d;
        if (acc_last) begin
          raw_q <= avg_d;
        end
      end
    end
  end

endmodule // sdoc_chan

// ### bench/sdoc_props.sv
`include "sdoc_defines.vh"
module sdoc_props (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_B,
  // modulator side
  input wire logic MOD_SAMPLE_STB,
  input wire logic [`SDOC_NCH-1:0] MOD_BITS,
  // configuration
  input wire logic [2:0] RATIO_SEL,
  input wire logic [1:0] WIDTH_SEL,
  // result side
  input wire logic DATA_READY,
  input wire logic SETTLED,
  input wire logic [`SDOC_NCH*`SDOC_OUT_W-1:0] CH_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_B);
  // ========
  // strobe counts
  logic [2:0] ratio_q;
  logic [1:0] sd_q;
  logic [15:0] scnt_q;
  logic [15:0] rcnt_q;
  wire chg = RATIO_SEL != ratio_q;
  // last cycle's ratio: a result seen in a change cycle belongs to the old setting
  wire [15:0] c3 = 16'h20 << ((ratio_q > 3'h4) ? 3'h4 : ratio_q);
  wire [15:0] c1 = (ratio_q > 3'h4) ? 16'h1 << (ratio_q - 3'h4) : 16'h1;
  wire [15:0] settle = (c1 + 16'h2) * c3;
  // strobe delayed by two so counts line up with result latency
  always @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ratio_q <= 3'h0;
      sd_q <= 2'h0;
      scnt_q <= 16'h0;
      rcnt_q <= 16'h0;
    end else begin
      ratio_q <= RATIO_SEL;
      sd_q <= {sd_q[0], MOD_SAMPLE_STB};
      scnt_q <= chg ? 16'h0 : scnt_q + 16'(MOD_SAMPLE_STB);
      rcnt_q <= (DATA_READY ? 16'h0 : rcnt_q) + 16'(sd_q[1]);
    end
  end
  // ========
  // properties
  sequence s_change;
    chg;
  endsequence
  sequence s_first;
    $rose(SETTLED) && DATA_READY;
  endsequence
  a_ready_pulse: assert property (DATA_READY |=> !DATA_READY [*8])
    else $error("data ready pulse too long or too close");
  a_ready_settled: assert property (DATA_READY |-> SETTLED)
    else $error("data ready without settled filter");
  a_restart_quiet: assert property (s_change |=> !SETTLED && !DATA_READY)
    else $error("ratio change did not restart settling");
  a_settle_min: assert property (DATA_READY |-> scnt_q >= settle)
    else $error("result before settling time");
  a_first_exact: assert property (s_first |-> scnt_q >= settle && scnt_q <= settle + 16'h2)
    else $error("first result not at settling time");
  a_ready_spacing: assert property (DATA_READY && $past(SETTLED) |-> rcnt_q == c1 * c3)
    else $error("result spacing differs from output period");
  a_data_hold: assert property (!DATA_READY |-> $stable(CH_DATA))
    else $error("channel data changed without data ready");
  a_settled_hold: assert property (SETTLED && !chg |=> SETTLED)
    else $error("settled dropped without ratio change");
endmodule // sdoc_props

// ### bench/sdoc_mod_src.sv
module sdoc_mod_src (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // strobe spacing in cycles, 1 to 3
  input wire logic [1:0] gap,
  // bitstream toward the filter
  output logic stb,
  output logic [5:0] bits
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic ph_q;
  // ch0/3 all +1, ch1/4 all -1, ch2/5 alternating
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 2'h0;
      ph_q <= 1'b0;
      stb <= 1'b0;
      bits <= 6'h0;
    end else if (cnt_q >= gap - 2'h1) begin
      cnt_q <= 2'h0;
      ph_q <= ~ph_q;
      stb <= 1'b1;
      bits <= {ph_q, 2'b01, ph_q, 2'b01};
    end else begin
      cnt_q <= cnt_q + 2'h1;
      stb <= 1'b0;
      // off-strobe bits inverted so sampling outside strobes shows up
      bits <= ~bits;
    end
  end
endmodule // sdoc_mod_src

// ### bench/sdoc_tb.sv
`include "sdoc_defines.vh"
`define CHK(g, e) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    err_total++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // stimulus and wiring
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] ratio_sel = 3'h0;
  logic [1:0] width_sel = 2'h1;
  logic [1:0] gap = 2'h1;
  logic stb;
  logic [`SDOC_NCH-1:0] bits;
  logic ready;
  logic settled;
  logic [`SDOC_NCH*`SDOC_OUT_W-1:0] ch_data;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  sdoc_top u_sdoc_top (.CLK(clk), .RST_B(rst_b), .MOD_SAMPLE_STB(stb), .MOD_BITS(bits),
    .RATIO_SEL(ratio_sel), .WIDTH_SEL(width_sel), .DATA_READY(ready), .SETTLED(settled),
    .CH_DATA(ch_data));
  sdoc_mod_src u_sdoc_mod_src (.clk(clk), .rst_b(rst_b), .gap(gap), .stb(stb), .bits(bits));
  initial forever #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      err_total++;
      report_and_stop();
    end
  end
  // ========
  // tasks
  task automatic report_and_stop;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic wait_ready(output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (ready !== 1'b1 && n < 9000);
  endtask
  task automatic t_settle(input logic [2:0] c);
    int n;
    int p;
    int s;
    p = (c > 3'h4) ? (1 << (c - 3'h4)) : 1;
    s = 32 << ((c > 3'h4) ? 4 : int'(c));
    @(posedge clk);
    ratio_sel <= c;
    wait_ready(n);
    `CHK(n >= (2 + p) * s + 2 && n <= (2 + p) * s + 3, 1'b1)
    `CHK(settled, 1'b1)
    `CHK(ch_data[23:0], 24'h7fffff)
    `CHK(ch_data[55:32], 24'h800000)
    `CHK(ch_data[87:64], 24'h000000)
    `CHK(ch_data[191:96], ch_data[95:0])
    wait_ready(n);
    `CHK(n, p * s)
  endtask
  task automatic t_restart;
    @(posedge clk);
    ratio_sel <= 3'h6;
    repeat (150) @(posedge clk);
    #1;
    `CHK({ready, settled}, 2'b00)
    t_settle(3'h0);
  endtask
  task automatic t_width;
    logic [31:0] e [4][3] = '{'{32'h7fff, 32'h8000, 32'h0},
      '{32'h7fffff, 32'h800000, 32'h0}, '{32'h7fffff00, 32'h80000000, 32'h0},
      '{32'h7fffff, 32'hff800000, 32'h0}};
    logic [31:0] m [4] = '{32'hffff, 32'hffffff, 32'hffffffff, 32'hffffffff};
    int n;
    for (int w = 0; w < 4; w++) begin
      @(posedge clk);
      width_sel <= 2'(w);
      wait_ready(n);
      wait_ready(n);
      for (int k = 0; k < 3; k++) begin
        `CHK(ch_data[k*32 +: 32] & m[w], e[w][k])
      end
    end
    @(posedge clk);
    width_sel <= 2'h1;
  endtask
  task automatic t_slow;
    int n;
    @(posedge clk);
    gap <= 2'h3;
    wait_ready(n);
    wait_ready(n);
    `CHK(n, 96)
  endtask
  // ========
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    `CHK({ready, settled, ch_data}, '0)
    @(posedge clk);
    rst_b <= 1'b1;
    for (int c = 1; c < 8; c++) begin
      t_settle(3'(c));
    end
    t_restart();
    t_width();
    t_slow();
    report_and_stop();
  end
endmodule // tb
bind sdoc_top sdoc_props u_sdoc_props (.CLK(CLK), .RST_B(RST_B), .MOD_SAMPLE_STB(MOD_SAMPLE_STB),
  .MOD_BITS(MOD_BITS), .RATIO_SEL(RATIO_SEL), .WIDTH_SEL(WIDTH_SEL), .DATA_READY(DATA_READY),
  .SETTLED(SETTLED), .CH_DATA(CH_DATA));
